// ==== design/mfm_pkg.sv ====
// Purpose: shared constants and carriers for the motor fault manager
// Assumes: 10 MHz system clock
// Notes:   monitor inputs are raw comparator levels from outside
//
// Functional notes
// - no stop-on-fault: short or bootstrap fault turns off that switch until next pwm-on
// - sync loss coasts the motor; restart bit 1 re-enters startup at once
// - restart bit 0 latches sync loss, drives off until demand/run/status-read/por
// - diagnostic bits latch; cleared only by por or a read with clear select 0
// - a mask bit suppresses its diagnostic fully; por and system error unmaskable
// - main supply below reset threshold disables outputs and resets all logic
// - leaving power-down restores registers, clears faults, sets any-fault and por flags
// - host reset held 10 ms after logic regulator valid, or first serial transfer if masked
// - the same power-on sequence runs for first power-up and brown-out
// - temperature warning only sets a latched flag
// - overtemp with stop-on-fault: flag, drives off, regulator off, host reset low
// - after overtemp clears, regulator off and reset low for a further 10 ms
// - overtemp without stop-on-fault only sets the latched flag
// - supply-low condition has hysteresis; its flag stays latched until cleared
// - supply-low with stop-on-fault disables drives; restart or latch on removal
// - supply-low mask disables both monitor and its action
// - gate supply low forces drives low, re-enables on recovery, flag latched
// - logic regulator low sets flag, host reset low, drives off
// - after regulator recovers, reset held 10 ms then released, watchdog reset
// - watchdog held in reset and input ignored 100 ms after host reset release
// - restart on first watchdog transition; restart bit 0 also needs a clearing event
// - stop-on-fault enable selects whether non-critical faults disable drives
package mfm_pkg;
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned RST_HOLD_MS  = 10;
    localparam int unsigned WD_HOLD_MS   = 100;
    localparam int unsigned RST_HOLD_CYC = CLK_HZ / 1000 * RST_HOLD_MS;
    localparam int unsigned WD_HOLD_CYC  = CLK_HZ / 1000 * WD_HOLD_MS;
    localparam int unsigned CNT_W        = 20;

    // mask bit positions
    localparam int unsigned MSK_SUPPLY   = 0;
    localparam int unsigned MSK_GATE     = 1;
    localparam int unsigned MSK_LOGIC    = 2;
    localparam int unsigned MSK_TWARN    = 3;
    localparam int unsigned MSK_OTEMP    = 4;
    localparam int unsigned MSK_SYNC     = 5;
    localparam int unsigned MSK_SHORT    = 6;
    localparam int unsigned MSK_W        = 7;

    typedef struct packed {
        logic       supply_low;
        logic       gate_supply_low;
        logic       logic_reg_low;
        logic       temp_warn;
        logic       overtemp;
        logic       sync_loss;
        logic       short_fault;
        logic [5:0] short_switch;
    } mfm_mon_type;

    typedef struct packed {
        logic any_fault_flag;
        logic por_flag;
        logic supply_low_flag;
        logic gate_supply_low_flag;
        logic logic_reg_low_flag;
        logic thermal_warning_flag;
        logic overtemp_flag;
        logic sync_loss_flag;
        logic short_flag;
    } mfm_flags_type;
endpackage

// ==== design/mfm_hold_timer.sv ====
// Purpose: retriggerable hold timer for reset and watchdog intervals
// Assumes: single clock domain
// Notes:   busy while counting; retrigger restarts the count
`timescale 1ns/1ps
`default_nettype none
module mfm_hold_timer #(
    parameter int unsigned CYCLES = 100
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic trigger,
    output logic      busy
);
    logic [mfm_pkg::CNT_W-1:0] cnt_q;
    logic [mfm_pkg::CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (trigger) begin
            cnt_d = mfm_pkg::CNT_W'(CYCLES);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = trigger || (cnt_q != '0);
endmodule
`default_nettype wire

// ==== design/mfm_sync2.sv ====
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to clock
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module mfm_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule
`default_nettype wire

// ==== design/mfm_fault_manager.sv ====
// Purpose: fault supervision, drive disable and host reset sequencing
// Assumes: rst_n is the main-supply power-on reset; control bits are
//          synchronous register outputs, monitors arrive from pins
// Notes:   flags are sticky; a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module mfm_fault_manager (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire mfm_pkg::mfm_mon_type  mon_pin,
    input  wire logic                  watchdog_in,
    input  wire logic                  stop_on_fault_enable,
    input  wire logic                  restart_after_fault,
    input  wire logic                  run_bit,
    input  wire logic                  demand_nonzero,
    input  wire logic [6:0]            mask,
    input  wire logic                  watchdog_mask_bit,
    input  wire logic                  serial_valid,
    input  wire logic                  status_read,
    input  wire logic                  diag_read,
    input  wire logic                  read_clear_sel,
    input  wire logic [5:0]            pwm_on,
    output mfm_pkg::mfm_flags_type     flags,
    output logic                       gate_enable_all,
    output logic [5:0]                 switch_enable,
    output logic                       startup_req,
    output logic                       logic_regulator_out,
    output logic                       host_reset_out_n,
    output logic                       watchdog_hold,
    output logic                       logic_io_enable
);
    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    mfm_pkg::mfm_mon_type mon_s;
    logic                 wd_s;

    mfm_sync2 #(.W($bits(mfm_pkg::mfm_mon_type) + 1)) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({mon_pin, watchdog_in}),
        .q     ({mon_s, wd_s})
    );

    // ------------------------------------------------------------
    // masking
    // ------------------------------------------------------------
    // masked monitors vanish: no flag, no state, no action, except raw regulator-low still gates logic_io_enable during power-up
    mfm_pkg::mfm_mon_type mon;
    always_comb begin
        mon = mon_s;
        if (mask[mfm_pkg::MSK_SUPPLY]) mon.supply_low = 1'b0;
        if (mask[mfm_pkg::MSK_GATE])   mon.gate_supply_low = 1'b0;
        if (mask[mfm_pkg::MSK_LOGIC])  mon.logic_reg_low = 1'b0;
        if (mask[mfm_pkg::MSK_TWARN])  mon.temp_warn = 1'b0;
        if (mask[mfm_pkg::MSK_OTEMP])  mon.overtemp = 1'b0;
        if (mask[mfm_pkg::MSK_SYNC])   mon.sync_loss = 1'b0;
        if (mask[mfm_pkg::MSK_SHORT]) begin
            mon.short_fault  = 1'b0;
            mon.short_switch = '0;
        end
    end

    // ------------------------------------------------------------
    // clearing events
    // ------------------------------------------------------------
    logic run_prev_q;
    logic dem_prev_q;
    logic wd_prev_q;
    logic run_reset;
    logic dem_reset;
    logic rd_clear;
    logic clear_evt;

    // other party performs these sequences
    assign run_reset = run_bit && !run_prev_q;
    assign dem_reset = demand_nonzero && !dem_prev_q;
    assign rd_clear  = (status_read || diag_read) && !read_clear_sel;
    assign clear_evt = run_reset || dem_reset
                       || (status_read && !read_clear_sel);

    // ------------------------------------------------------------
    // host reset and watchdog sequencing
    // ------------------------------------------------------------
    logic ot_stop;
    logic rst_trig;
    logic rst_busy;
    logic hold_rel;
    logic wd_busy;
    logic por_seq_q;
    logic por_seq_d;
    logic rel_prev_q;
    logic host_rel;
    logic wd_edge;
    logic ot_busy;
    logic early_q;
    logic early_d;
    logic [1:0] settle_q;

    assign ot_stop  = mon.overtemp && stop_on_fault_enable;
    // retriggered while any cause persists, so count runs after it clears
    assign rst_trig = mon.logic_reg_low
                      || ot_stop;

    // monitors are unknown until both sync stages fill, so hold meanwhile
    mfm_hold_timer #(.CYCLES(mfm_pkg::RST_HOLD_CYC)) u_rst_hold (
        .clock   (clock),
        .rst_n   (rst_n),
        .trigger (rst_trig || !settle_q[1]),
        .busy    (rst_busy)
    );

    // own timer: the regulator must not wait out a regulator-low hold
    mfm_hold_timer #(.CYCLES(mfm_pkg::RST_HOLD_CYC)) u_ot_hold (
        .clock   (clock),
        .rst_n   (rst_n),
        .trigger (ot_stop),
        .busy    (ot_busy)
    );

    // early release by a serial transfer only on the power-up hold
    always_comb begin
        por_seq_d = por_seq_q;
        early_d   = early_q;
        if (ot_stop || host_rel) begin
            por_seq_d = 1'b0;
        end
        // a transfer before the monitors settle proves nothing
        if (rst_trig) begin
            early_d = 1'b0;
        end else if (por_seq_q && settle_q[1] && serial_valid
                     && watchdog_mask_bit) begin
            early_d = 1'b1;
        end
    end

    // the early release is kept until the next hold cause
    assign hold_rel = !rst_busy || early_q;
    assign host_rel = hold_rel && !rst_trig;
    assign wd_edge  = (wd_s != wd_prev_q) && !wd_busy;

    mfm_hold_timer #(.CYCLES(mfm_pkg::WD_HOLD_CYC)) u_wd_hold (
        .clock   (clock),
        .rst_n   (rst_n),
        .trigger (host_rel && !rel_prev_q),
        .busy    (wd_busy)
    );

    // ------------------------------------------------------------
    // fault states
    // ------------------------------------------------------------
    logic       sync_lat_q;
    logic       sync_lat_d;
    logic       sup_lat_q;
    logic       sup_lat_d;
    logic       short_lat_q;
    logic       short_lat_d;
    logic       wd_wait_q;
    logic       wd_wait_d;
    logic       wd_lat_q;
    logic       wd_lat_d;
    logic [5:0] sw_off_q;
    logic [5:0] sw_off_d;
    logic       sup_prev_q;
    logic       start_d;
    logic       start_q;

    always_comb begin
        sync_lat_d  = sync_lat_q;
        sup_lat_d   = sup_lat_q;
        short_lat_d = short_lat_q;
        wd_wait_d   = wd_wait_q;
        wd_lat_d    = wd_lat_q;
        sw_off_d    = sw_off_q & ~pwm_on;
        start_d     = 1'b0;
        if (clear_evt) begin
            sync_lat_d  = 1'b0;
            sup_lat_d   = 1'b0;
            short_lat_d = 1'b0;
        end
        if (diag_read && !read_clear_sel) short_lat_d = 1'b0;
        if (mon.sync_loss) begin
            if (restart_after_fault && run_bit && demand_nonzero) begin
                start_d = 1'b1;
            end else if (!restart_after_fault) begin
                sync_lat_d = 1'b1;
            end
        end
        if (stop_on_fault_enable && sup_prev_q && !mon.supply_low) begin
            if (restart_after_fault) begin
                start_d = 1'b1;
            end else begin
                sup_lat_d = 1'b1;
            end
        end
        if (mon.short_fault) begin
            if (stop_on_fault_enable) begin
                short_lat_d = 1'b1;
            end else begin
                sw_off_d = sw_off_d | mon.short_switch;
            end
        end
        // host-side recovery waits for first watchdog transition
        if (rst_trig) begin
            wd_wait_d = 1'b1;
            wd_lat_d  = !restart_after_fault;
        end else if (wd_wait_q && wd_edge) begin
            wd_wait_d = 1'b0;
            start_d   = restart_after_fault && run_bit && demand_nonzero;
        end
        if (wd_lat_q && !wd_wait_q && clear_evt) begin
            wd_lat_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_lat_q  <= 1'b0;
            sup_lat_q   <= 1'b0;
            short_lat_q <= 1'b0;
            wd_wait_q   <= 1'b1;
            wd_lat_q    <= 1'b0;
            sw_off_q    <= '0;
            sup_prev_q  <= 1'b0;
            start_q     <= 1'b0;
            run_prev_q  <= 1'b0;
            dem_prev_q  <= 1'b0;
            wd_prev_q   <= 1'b0;
            rel_prev_q  <= 1'b0;
            por_seq_q   <= 1'b1;
            early_q     <= 1'b0;
            settle_q    <= '0;
        end else begin
            sync_lat_q  <= sync_lat_d;
            sup_lat_q   <= sup_lat_d;
            short_lat_q <= short_lat_d;
            wd_wait_q   <= wd_wait_d;
            wd_lat_q    <= wd_lat_d;
            sw_off_q    <= sw_off_d;
            sup_prev_q  <= mon.supply_low;
            start_q     <= start_d;
            run_prev_q  <= run_bit;
            dem_prev_q  <= demand_nonzero;
            wd_prev_q   <= wd_s;
            rel_prev_q  <= host_rel;
            por_seq_q   <= por_seq_d;
            early_q     <= early_d;
            settle_q    <= {settle_q[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    mfm_pkg::mfm_flags_type flg_q;
    mfm_pkg::mfm_flags_type flg_d;
    logic                   any_set;

    always_comb begin
        flg_d   = flg_q;
        // clear first so a simultaneous set wins
        if (rd_clear) begin
            flg_d = '0;
        end
        any_set = mon.supply_low || mon.gate_supply_low
                  || mon.logic_reg_low || mon.temp_warn || mon.overtemp
                  || mon.sync_loss || mon.short_fault;
        if (mon.supply_low) flg_d.supply_low_flag = 1'b1;
        if (mon.gate_supply_low) flg_d.gate_supply_low_flag = 1'b1;
        if (mon.logic_reg_low) flg_d.logic_reg_low_flag = 1'b1;
        if (mon.temp_warn) flg_d.thermal_warning_flag = 1'b1;
        if (mon.overtemp) flg_d.overtemp_flag = 1'b1;
        if (mon.sync_loss) flg_d.sync_loss_flag = 1'b1;
        if (mon.short_fault) flg_d.short_flag = 1'b1;
        if (any_set) flg_d.any_fault_flag = 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flg_q                <= '0;
            flg_q.any_fault_flag <= 1'b1;
            flg_q.por_flag       <= 1'b1;
        end else begin
            flg_q <= flg_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // critical faults always disable; supply-low, overtemp and short disable all drives only with stop enabled
    assign gate_enable_all = !mon.gate_supply_low
        && !mon.logic_reg_low && !rst_busy
        && !ot_stop
        && !mon.sync_loss && !sync_lat_q
        && !(stop_on_fault_enable && mon.supply_low)
        && !sup_lat_q && !short_lat_q
        && !wd_wait_q && !wd_lat_q;
    assign switch_enable = {6{gate_enable_all}} & ~sw_off_q;
    assign startup_req   = start_q;
    assign logic_regulator_out = !ot_busy;
    assign host_reset_out_n = host_rel;
    assign watchdog_hold    = wd_busy;
    assign logic_io_enable  = !(por_seq_q && (mon_s.logic_reg_low
                                || !settle_q[1]));
    assign flags = flg_q;
endmodule
`default_nettype wire

// ==== testbench/mfm_fault_manager_chk.sv ====
// Purpose: port checks for the fault manager
// Assumes: one clock, rst_n async active low
// Notes:   hold counters start at the raw pin, so sync lag is slack
`timescale 1ns/1ps
`default_nettype none
module mfm_fault_manager_chk (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire mfm_pkg::mfm_mon_type   mon_pin,
    input wire logic                   stop_on_fault_enable,
    input wire logic [6:0]             mask,
    input wire logic                   watchdog_mask_bit,
    input wire logic                   serial_valid,
    input wire logic                   status_read,
    input wire logic                   diag_read,
    input wire logic                   read_clear_sel,
    input wire mfm_pkg::mfm_flags_type flags,
    input wire logic                   gate_enable_all,
    input wire logic                   logic_regulator_out,
    input wire logic                   host_reset_out_n
);
    localparam logic [19:0] HOLD = 20'(mfm_pkg::RST_HOLD_CYC);
    logic [19:0] lr_q, lr_d, ot_q, ot_d;
    logic        sv_q, sv_d, ot_on, clr;
    logic [8:0]  fv;
    assign ot_on = mon_pin.overtemp && stop_on_fault_enable && !mask[4];
    assign clr   = (status_read || diag_read) && !read_clear_sel;
    assign fv    = flags;
    // ---------------------------------------------------------------
    // cycles since each hold cause was last seen, saturating
    // ---------------------------------------------------------------
    always_comb begin
        lr_d = (lr_q > HOLD) ? lr_q : lr_q + 20'h1;
        ot_d = (ot_q > HOLD) ? ot_q : ot_q + 20'h1;
        sv_d = sv_q || serial_valid;
        if (mon_pin.logic_reg_low && !mask[2]) begin
            lr_d = 20'h0;
            sv_d = 1'b0;
        end
        if (ot_on) begin
            ot_d = 20'h0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lr_q <= 20'hFFFFF;
            ot_q <= 20'hFFFFF;
            sv_q <= 1'b0;
        end else begin
            lr_q <= lr_d;
            ot_q <= ot_d;
            sv_q <= sv_d;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_lr; (mon_pin.logic_reg_low && !mask[2]) [*3]; endsequence
    sequence s_ot; ot_on [*3]; endsequence
    sequence s_quiet; (mon_pin == '0) [*3]; endsequence
    chk_lr_reset: assert property (
        s_lr |-> !host_reset_out_n && !gate_enable_all
        ##1 flags.logic_reg_low_flag) else $error("regulator low ignored");
    // an early serial release is legal, so those cycles are skipped
    chk_lr_hold: assert property (
        lr_q >= 20'h3 && lr_q < HOLD && !(watchdog_mask_bit &&
        (sv_q || serial_valid)) |-> !host_reset_out_n)
        else $error("host reset released early");
    chk_ot_shutdown: assert property (
        s_ot |-> !logic_regulator_out && !host_reset_out_n)
        else $error("overtemp did not shut down");
    chk_ot_hold: assert property (
        ot_q >= 20'h3 && ot_q < HOLD |->
        !logic_regulator_out && !host_reset_out_n)
        else $error("overtemp hold too short");
    chk_ot_no_sof: assert property (
        (mon_pin.overtemp && !stop_on_fault_enable && ot_q > HOLD) [*3]
        |-> logic_regulator_out) else $error("overtemp acted");
    chk_flag_sticky: assert property (
        !clr |=> (fv & $past(fv)) == $past(fv))
        else $error("flag dropped without read");
    chk_twarn_sets: assert property (
        (mon_pin.temp_warn && !mask[3]) [*3] |=> flags.thermal_warning_flag)
        else $error("warning flag not set");
    chk_twarn_mask: assert property (
        mask[3] [*5] |-> !$rose(flags.thermal_warning_flag))
        else $error("masked warning flagged");
    chk_supply_mask: assert property (
        mask[0] [*5] |-> !$rose(flags.supply_low_flag))
        else $error("masked supply flagged");
    chk_read_clear: assert property (
        s_quiet ##0 clr |=> !flags.thermal_warning_flag &&
        !flags.supply_low_flag) else $error("read did not clear");
endmodule
`default_nettype wire

// ==== testbench/mfm_host_model.sv ====
// Purpose: behavioural host that kicks the watchdog
// Assumes: kicks only while out of reset
// Notes:   a held host stops toggling, as a real one would
`timescale 1ns/1ps
`default_nettype none
module mfm_host_model #(
    parameter int unsigned PERIOD = 40
) (
    input  wire logic clock,
    input  wire logic host_reset_out_n,
    output var logic  watchdog_in
);
    int unsigned cnt;
    initial begin
        watchdog_in = 1'b0;
        cnt = 0;
    end
    // either edge of the kick counts as a transition
    always @(posedge clock) begin
        #10;
        if (!host_reset_out_n) begin
            cnt = 0;
        end else if (cnt == PERIOD - 1) begin
            cnt = 0;
            watchdog_in = !watchdog_in;
        end else begin
            cnt = cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/mfm_fault_manager_test.sv ====
// Purpose: directed test of the fault manager
// Assumes: package counts as shipped; long holds only partly run
// Notes:   watchdog hold-off is too long to see the drives return
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin \
    comparisons++; \
    if ((sn) !== (ex)) begin \
        bad_count++; \
        $display("Error %s expected %0h seen %0h", nm, (ex), (sn)); \
    end \
end
module mfm_fault_manager_test;
    logic                   clock, rst_n, watchdog_in, startup_req;
    logic                   stop_on_fault_enable, restart_after_fault;
    logic                   run_bit, demand_nonzero, watchdog_mask_bit;
    logic                   serial_valid, status_read, diag_read;
    logic                   read_clear_sel, gate_enable_all, watchdog_hold;
    logic                   logic_regulator_out, host_reset_out_n;
    logic                   logic_io_enable;
    logic [6:0]             mask;
    logic [5:0]             pwm_on, switch_enable;
    logic [12:0]            mon_v;
    logic [8:0]             flag_v;
    mfm_pkg::mfm_mon_type   mon_pin;
    mfm_pkg::mfm_flags_type flags, ef;
    int                     bad_count, comparisons;
    int unsigned            ids [5] = '{0, 1, 3, 5, 6};
    assign mon_pin = mon_v;
    assign flag_v  = flags;
    mfm_fault_manager dut (.clock(clock), .rst_n(rst_n), .mon_pin(mon_pin),
        .watchdog_in(watchdog_in), .run_bit(run_bit),
        .stop_on_fault_enable(stop_on_fault_enable),
        .restart_after_fault(restart_after_fault),
        .demand_nonzero(demand_nonzero), .mask(mask),
        .watchdog_mask_bit(watchdog_mask_bit), .serial_valid(serial_valid),
        .status_read(status_read), .diag_read(diag_read),
        .read_clear_sel(read_clear_sel), .pwm_on(pwm_on), .flags(flags),
        .gate_enable_all(gate_enable_all), .switch_enable(switch_enable),
        .startup_req(startup_req), .logic_regulator_out(logic_regulator_out),
        .host_reset_out_n(host_reset_out_n), .watchdog_hold(watchdog_hold),
        .logic_io_enable(logic_io_enable));
    mfm_host_model host (.clock(clock), .host_reset_out_n(host_reset_out_n),
        .watchdog_in(watchdog_in));
    always #50 clock = ~clock;
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask
    task automatic rd(input logic sel, input logic dg);
        read_clear_sel = sel;
        status_read = !dg;
        diag_read = dg;
        tick(1);
        status_read = 1'b0;
        diag_read = 1'b0;
        tick(1);
    endtask
    task automatic pulse_serial();
        serial_valid = 1'b1;
        tick(1);
        serial_valid = 1'b0;
        tick(3);
    endtask
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        bad_count++;
        test_done();
    end
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        bad_count = 0;
        comparisons = 0;
        ef = '0;
        ef.any_fault_flag = 1'b1;
        ef.por_flag = 1'b1;
        stop_on_fault_enable = 1'b1;
        restart_after_fault = 1'b1;
        run_bit = 1'b1;
        demand_nonzero = 1'b1;
        watchdog_mask_bit = 1'b1;
        serial_valid = 1'b0;
        status_read = 1'b0;
        diag_read = 1'b0;
        read_clear_sel = 1'b1;
        mask = 7'h00;
        pwm_on = 6'h3F;
        mon_v = 13'h0400;
        tick(5);
        rst_n = 1'b1;
        tick(1);
        `CHK("flags", ef, flags)
        `CHK("host_reset", 1'b0, host_reset_out_n)
        `CHK("io_enable", 1'b0, logic_io_enable)
        tick(3);
        `CHK("lr_flag", 1'b1, flags.logic_reg_low_flag)
        mon_v = 13'h0;
        tick(500);
        `CHK("host_reset", 1'b0, host_reset_out_n)
        `CHK("io_enable", 1'b1, logic_io_enable)
        pulse_serial();
        `CHK("host_reset", 1'b1, host_reset_out_n)
        `CHK("wd_hold", 1'b1, watchdog_hold)
        tick(200);
        `CHK("gates", 1'b0, gate_enable_all)
        `CHK("switches", 6'h00, switch_enable)
        foreach (ids[k]) begin
            rd(1'b0, 1'b1);
            mask = 7'h01 << ids[k];
            mon_v[12 - ids[k]] = 1'b1;
            tick(4);
            `CHK("masked", 1'b0, flag_v[6 - ids[k]])
            mon_v = 13'h0;
            tick(3);
            mask = 7'h00;
            tick(3);
            mon_v[12 - ids[k]] = 1'b1;
            tick(4);
            `CHK("flag", 1'b1, flag_v[6 - ids[k]])
            `CHK("host_reset", 1'b1, host_reset_out_n)
            mon_v = 13'h0;
            tick(4);
            rd(1'b1, ids[k][0]);
            `CHK("kept", 1'b1, flag_v[6 - ids[k]])
            rd(1'b0, !ids[k][0]);
            `CHK("cleared", 1'b0, flag_v[6 - ids[k]])
        end
        mon_v[7] = 1'b1;
        tick(3);
        `CHK("startup", 1'b1, startup_req)
        tick(1);
        mon_v = 13'h0;
        run_bit = 1'b0;
        tick(2);
        run_bit = 1'b1;
        demand_nonzero = 1'b0;
        tick(2);
        demand_nonzero = 1'b1;
        tick(2);
        `CHK("sync_flag", 1'b1, flags.sync_loss_flag)
        stop_on_fault_enable = 1'b0;
        mon_v[8] = 1'b1;
        tick(5);
        `CHK("ot_flag", 1'b1, flags.overtemp_flag)
        `CHK("regulator", 1'b1, logic_regulator_out)
        `CHK("host_reset", 1'b1, host_reset_out_n)
        stop_on_fault_enable = 1'b1;
        tick(4);
        `CHK("regulator", 1'b0, logic_regulator_out)
        `CHK("host_reset", 1'b0, host_reset_out_n)
        mon_v = 13'h0;
        tick(1000);
        `CHK("regulator", 1'b0, logic_regulator_out)
        `CHK("host_reset", 1'b0, host_reset_out_n)
        rst_n = 1'b0;
        mon_v[10] = 1'b1;
        watchdog_mask_bit = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
        `CHK("flags", ef, flags)
        `CHK("regulator", 1'b1, logic_regulator_out)
        mon_v = 13'h0;
        tick(100);
        pulse_serial();
        `CHK("host_reset", 1'b0, host_reset_out_n)
        tick(1000);
        `CHK("host_reset", 1'b0, host_reset_out_n)
        test_done();
    end
endmodule
bind mfm_fault_manager mfm_fault_manager_chk chk (.clock(clock),
    .rst_n(rst_n), .mon_pin(mon_pin), .mask(mask), .flags(flags),
    .stop_on_fault_enable(stop_on_fault_enable), .diag_read(diag_read),
    .watchdog_mask_bit(watchdog_mask_bit), .serial_valid(serial_valid),
    .status_read(status_read), .read_clear_sel(read_clear_sel),
    .gate_enable_all(gate_enable_all), .host_reset_out_n(host_reset_out_n),
    .logic_regulator_out(logic_regulator_out));
`default_nettype wire
